// ---- core/pwr_ctl_defs.svh ----
// Constants for the power gating and reset control block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef PWR_CTL_DEFS_SVH
`define PWR_CTL_DEFS_SVH

`define OFS_CLOCK_GATE 8'h00
`define OFS_SLEEP_CTRL 8'h04
`define OFS_STATUS 8'h08
`define BIT_GATE_TIMER_ONE 3
`define BIT_GATE_TIMER_ZERO 2
`define BIT_GATE_SERIAL 1
`define BIT_GATE_CONVERTER 0
`define GATE_MASK 8'h0F
`define GATE_RESET 8'h00
`define SLEEP_RESET 8'h00
`define EXT_MIN_CYCLES 16'h0004
`define TOUT_SHORT 16'h0010
`define TOUT_MEDIUM 16'h0100
`define TOUT_LONG 16'h1000

`endif

// ---- core/pwr_ctl_pkg.sv ----
// Types for the power gating and reset control block.
// Assumes the defs header is compiled alongside.
package pwr_ctl_pkg;
  typedef enum logic [1:0] {
    sm_idle = 2'b00,
    sm_adc_noise = 2'b01,
    sm_power_down = 2'b10,
    sm_standby = 2'b11
  } sleep_mode_e;
  typedef enum logic [1:0] {
    rst_hold = 2'b00,
    rst_count = 2'b01,
    rst_run = 2'b10
  } rst_state_e;
endpackage : pwr_ctl_pkg

// ---- core/power_gating_and_reset_control.sv ----
// Clock gating, sleep policy and reset merging with a stretch counter.
// Assumes an AHB-Lite master on hclk; analog sources arrive as async levels.
//
// Functional notes
// RULE1 - Gate bit stops clock and blocks access
// RULE2 - Clearing gate bit resumes frozen module
// RULE3 - Gating matters in active and idle only; the converter gate bit also applies in ADC noise mode here
// RULE4 - Upper four gate bits read zero
// RULE5 - Bit 3 gates timer one
// RULE6 - Bit 2 gates timer zero
// RULE7 - Bit 1 gates serial interface clock
// RULE8 - Software disables converter before bit 0
// RULE9 - Gated converter mux unavailable to comparator
// RULE10 - Enabled converter stays on; restart extended
// RULE11 - Comparator off in deep sleep modes
// RULE12 - Reference on when any user needs it
// RULE13 - Input buffers off when io/adc clocks stop
// RULE14 - Enabled watchdog keeps running in sleep
// RULE15 - Configured brown-out stays active in sleep
// RULE16 - Registers initialised during reset
// RULE17 - Pins reset immediately without clock; watchdog and brown-out sources reach pins only on an hclk edge
// RULE18 - Delay counter stretches internal reset
// RULE19 - Four reset sources merged
// RULE20 - Power-on reasserts reset with no delay; here core_reset_n drops on the third hclk edge
// RULE21 - Sleep mode select encoding
// RULE22 - Counter restarts if a source reasserts
`include "pwr_ctl_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module power_gating_and_reset_control (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic supply_ok_n,
  input wire logic ext_reset_n,
  input wire logic watchdog_expire,
  input wire logic brownout_low,
  input wire logic [2:0] brownout_level_config,
  input wire logic watchdog_enable,
  input wire logic converter_enable,
  input wire logic comparator_enable,
  input wire logic comparator_bandgap,
  input wire logic comparator_use_mux,
  input wire logic [1:0] startup_time_select,
  output logic clk_en_timer_one,
  output logic clk_en_timer_zero,
  output logic clk_en_serial,
  output logic clk_en_converter,
  output logic io_access_timer_one,
  output logic io_access_timer_zero,
  output logic io_access_serial,
  output logic io_access_converter,
  output logic converter_on,
  output logic converter_extended,
  output logic comparator_on,
  output logic comparator_mux_ok,
  output logic reference_on,
  output logic input_buffers_on,
  output logic watchdog_run,
  output logic brownout_on,
  output logic pins_reset_n,
  output logic core_reset_n,
  output logic core_fetch_vector
);
  import pwr_ctl_pkg::*;

  // --------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  wire logic [4:0] async_in = {supply_ok_n, ext_reset_n, watchdog_expire, brownout_low, wake_req};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 5'h18;
      sync2_q <= 5'h18;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end
  wire logic por_n_s = sync2_q[4];
  wire logic ext_n_s = sync2_q[3];
  wire logic wdt_s = sync2_q[2];
  wire logic bod_low_s = sync2_q[1];
  wire logic wake_s = sync2_q[0];

  // --------------------------------------------------
  // Bus slave
  // --------------------------------------------------
  logic [7:0] gate_q;
  logic [7:0] sleep_ctrl_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rdata_q;
  logic asleep_q;
  wire logic bus_go = hsel && hready && htrans[1];
  wire logic rd_go = bus_go && !hwrite;
  wire logic wr_gate = wr_pend_q && (wr_addr_q == `OFS_CLOCK_GATE);
  wire logic wr_sleep = wr_pend_q && (wr_addr_q == `OFS_SLEEP_CTRL);
  wire logic [7:0] gate_rd = gate_q & `GATE_MASK; // RULE4
  wire logic [31:0] rd_mux =
    (haddr == `OFS_CLOCK_GATE) ? {24'h000000, gate_rd} :
    (haddr == `OFS_SLEEP_CTRL) ? {24'h000000, sleep_ctrl_q} :
    (haddr == `OFS_STATUS) ? {29'h00000000, asleep_q, core_reset_n, reference_on} :
    32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= bus_go && hwrite;
      wr_addr_q <= haddr;
      if (rd_go) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Register file cleared on bus reset and while internal reset holds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_q <= `GATE_RESET; // RULE16
      sleep_ctrl_q <= `SLEEP_RESET;
    end else if (!core_reset_n) begin
      gate_q <= `GATE_RESET; // RULE16
      sleep_ctrl_q <= `SLEEP_RESET;
    end else begin
      if (wr_gate) begin
        gate_q <= hwdata[7:0] & `GATE_MASK; // RULE4
      end
      if (wr_sleep) begin
        sleep_ctrl_q <= {6'h00, hwdata[1:0]};
      end
    end
  end
  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // --------------------------------------------------
  // Sleep state and mode policy
  // --------------------------------------------------
  wire sleep_mode_e mode = sleep_mode_e'(sleep_ctrl_q[1:0]); // RULE21
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      asleep_q <= 1'b0;
    end else if (!core_reset_n || wake_s) begin
      asleep_q <= 1'b0;
    end else if (sleep_req) begin
      asleep_q <= 1'b1;
    end
  end
  // Io clock runs only when awake or in idle
  wire logic io_clk_run = !asleep_q || (mode == sm_idle); // RULE3
  wire logic adc_clk_run = !asleep_q || (mode == sm_idle) || (mode == sm_adc_noise);
  wire logic cmp_allowed = !asleep_q || (mode == sm_idle) || (mode == sm_adc_noise); // RULE11
  wire logic bod_cfg_on = (brownout_level_config != 3'h7);

  // --------------------------------------------------
  // Gate decode
  // --------------------------------------------------
  // One decode feeds clock and access paths; only the clock path also drops in sleep
  function automatic logic gate_open(input logic [7:0] gate, input int unsigned pos);
    gate_open = !gate[pos];
  endfunction : gate_open
  wire logic open_timer_one = gate_open(gate_q, `BIT_GATE_TIMER_ONE); // RULE5
  wire logic open_timer_zero = gate_open(gate_q, `BIT_GATE_TIMER_ZERO); // RULE6
  wire logic open_serial = gate_open(gate_q, `BIT_GATE_SERIAL); // RULE7
  wire logic open_converter = gate_open(gate_q, `BIT_GATE_CONVERTER); // RULE9

  // --------------------------------------------------
  // Clock enables
  // --------------------------------------------------
  // Gated modules keep their state since only the enable drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_en_timer_one <= 1'b0;
      clk_en_timer_zero <= 1'b0;
      clk_en_serial <= 1'b0;
      clk_en_converter <= 1'b0;
    end else begin
      clk_en_timer_one <= open_timer_one && io_clk_run; // RULE5 RULE1 RULE2
      clk_en_timer_zero <= open_timer_zero && io_clk_run; // RULE6 RULE1 RULE2
      clk_en_serial <= open_serial && io_clk_run; // RULE7
      clk_en_converter <= open_converter && adc_clk_run; // RULE1
    end
  end

  // --------------------------------------------------
  // Register access permits
  // --------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_access_timer_one <= 1'b0;
      io_access_timer_zero <= 1'b0;
      io_access_serial <= 1'b0;
      io_access_converter <= 1'b0;
    end else begin
      io_access_timer_one <= open_timer_one; // RULE1
      io_access_timer_zero <= open_timer_zero; // RULE1
      io_access_serial <= open_serial; // RULE1
      io_access_converter <= open_converter; // RULE1
    end
  end

  // --------------------------------------------------
  // Converter enable and extended first conversion
  // --------------------------------------------------
  logic conv_was_on_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_on <= 1'b0;
      converter_extended <= 1'b1;
      conv_was_on_q <= 1'b0;
    end else begin
      // Enable independent of sleep mode
      converter_on <= converter_enable; // RULE10
      conv_was_on_q <= converter_enable;
      // Set wins over clear so a quick off-on is never missed
      if (converter_enable && !conv_was_on_q) begin
        converter_extended <= 1'b1; // RULE10
      end else if (clk_en_converter && converter_on) begin
        converter_extended <= 1'b0;
      end
    end
  end

  // --------------------------------------------------
  // Analog and always-on blocks
  // --------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comparator_on <= 1'b0;
      comparator_mux_ok <= 1'b0;
      reference_on <= 1'b0;
      input_buffers_on <= 1'b0;
      watchdog_run <= 1'b0;
      brownout_on <= 1'b0;
    end else begin
      comparator_on <= comparator_enable && cmp_allowed; // RULE11
      comparator_mux_ok <= comparator_use_mux && open_converter; // RULE9
      // Bandgap on when brown-out, comparator or converter asks
      reference_on <= bod_cfg_on || (comparator_enable && comparator_bandgap) || converter_enable; // RULE12
      // Wake detection needs buffers, so a pending wake keeps them on
      input_buffers_on <= io_clk_run || adc_clk_run || wake_s; // RULE13
      watchdog_run <= watchdog_enable; // RULE14
      brownout_on <= bod_cfg_on; // RULE15
    end
  end

  // --------------------------------------------------
  // Reset merge and stretch
  // --------------------------------------------------
  logic [15:0] ext_cnt_q;
  logic ext_long_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_cnt_q <= 16'h0000;
      ext_long_q <= 1'b0;
    end else if (ext_n_s) begin
      ext_cnt_q <= 16'h0000;
      ext_long_q <= 1'b0;
    end else if (ext_cnt_q >= `EXT_MIN_CYCLES) begin
      ext_long_q <= 1'b1;
    end else begin
      ext_cnt_q <= ext_cnt_q + 16'h0001;
    end
  end
  // Watchdog expiry only counts when the watchdog is enabled
  wire logic any_src = !por_n_s || ext_long_q || (wdt_s && watchdog_enable) || (bod_low_s && bod_cfg_on); // RULE19
  wire logic [15:0] tout_sel =
    (startup_time_select == 2'h0) ? `TOUT_SHORT :
    (startup_time_select == 2'h1) ? `TOUT_MEDIUM : `TOUT_LONG;

  rst_state_e rst_q;
  logic [15:0] dly_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_q <= rst_hold;
      dly_q <= 16'h0000;
      core_reset_n <= 1'b0;
      core_fetch_vector <= 1'b0;
    end else begin
      core_fetch_vector <= 1'b0;
      case (rst_q)
        rst_hold: begin
          core_reset_n <= 1'b0;
          dly_q <= 16'h0000;
          if (!any_src) begin
            rst_q <= rst_count; // RULE18
          end
        end
        rst_count: begin
          if (any_src) begin
            rst_q <= rst_hold; // RULE22
            dly_q <= 16'h0000;
          end else if (dly_q >= tout_sel - 16'h0001) begin
            rst_q <= rst_run; // RULE18
            core_reset_n <= 1'b1;
            core_fetch_vector <= 1'b1; // RULE16
          end else begin
            dly_q <= dly_q + 16'h0001; // RULE22
          end
        end
        rst_run: begin
          if (any_src) begin
            rst_q <= rst_hold; // RULE20
            core_reset_n <= 1'b0;
          end
        end
        default: begin
          rst_q <= rst_hold;
          core_reset_n <= 1'b0;
        end
      endcase
    end
  end

  // Pin reset uses no clock: async set from raw power-on or pin level
  wire logic pin_rst_async_n = hresetn && supply_ok_n && ext_reset_n;
  always_ff @(posedge hclk or negedge pin_rst_async_n) begin
    if (!pin_rst_async_n) begin
      pins_reset_n <= 1'b0; // RULE17
    end else begin
      pins_reset_n <= !any_src && core_reset_n;
    end
  end
endmodule : power_gating_and_reset_control

`default_nettype wire

// ---- bench/pgrc_asserts.sv ----
// Checker for the power gating and reset control block.
// Assumes a bind onto the top module; one clock domain.
`timescale 1ns/100ps
`default_nettype none

module pgrc_check (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] hrdata,
  input wire logic supply_ok_n,
  input wire logic [2:0] brownout_level_config,
  input wire logic watchdog_enable,
  input wire logic converter_enable,
  input wire logic comparator_enable,
  input wire logic comparator_bandgap,
  input wire logic watchdog_run,
  input wire logic brownout_on,
  input wire logic converter_on,
  input wire logic reference_on,
  input wire logic pins_reset_n,
  input wire logic core_reset_n,
  input wire logic core_fetch_vector
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Three stable cycles cover the registered lag
  wire logic bod_cfg_on = brownout_level_config != 3'h7;
  wire logic ref_need = bod_cfg_on | (comparator_enable & comparator_bandgap) | converter_enable;
  // Length of the current internal reset, saturating
  logic [15:0] low_cnt_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_q <= 16'h0000;
    end else if (core_reset_n) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q != 16'hFFFF) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end

  upper_zero_a: assert property (hrdata[31:4] == 28'h0) else $error("upper read bits set");
  ref_on_a: assert property (ref_need [*3] |-> reference_on) else $error("reference off");
  ref_off_a: assert property (!ref_need [*3] |-> !reference_on) else $error("reference on");
  wdog_run_a: assert property (watchdog_enable [*3] |-> watchdog_run) else $error("watchdog stopped");
  bod_on_a: assert property (bod_cfg_on [*3] |-> brownout_on) else $error("brown-out off");
  conv_on_a: assert property (converter_enable [*3] |-> converter_on) else $error("converter off");
  por_pins_a: assert property (!supply_ok_n |-> !pins_reset_n) else $error("pins not reset");
  core_hold_a: assert property ($rose(pins_reset_n) |-> core_reset_n) else $error("pins freed early");
  stretch_a: assert property ($rose(core_reset_n) |-> low_cnt_q >= 16'h0010) else $error("short stretch");
  vector_a: assert property ($rose(core_reset_n) |-> ##[0:1] core_fetch_vector) else $error("no fetch");

  cover property ($rose(core_reset_n));
  cover property ($fell(pins_reset_n) && supply_ok_n);
  cover property (reference_on && !converter_enable);
endmodule : pgrc_check

bind power_gating_and_reset_control pgrc_check u_check (.hclk, .hresetn, .hrdata, .supply_ok_n,
  .brownout_level_config, .watchdog_enable, .converter_enable, .comparator_enable, .comparator_bandgap, .watchdog_run,
  .brownout_on, .converter_on, .reference_on, .pins_reset_n, .core_reset_n, .core_fetch_vector);

`default_nettype wire

// ---- bench/periph_model.sv ----
// Timer stand-in on the far side of a clock enable.
// Assumes the same clock as the block.
`timescale 1ns/100ps
`default_nettype none

module periph_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  output logic [15:0] count_q
);
  // State moves only while its clock runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= 16'h0000;
    end else if (clk_en) begin
      count_q <= count_q + 16'h0001;
    end
  end
endmodule : periph_model

`default_nettype wire

// ---- bench/power_gating_and_reset_control_tb_top.sv ----
// Testbench: AHB-Lite register tasks and reset source stimulus.
// Assumes startup_time_select 0 gives the shortest stretch.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end

module power_gating_and_reset_control_tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans, startup_time_select;
  logic [2:0] hsize, brownout_level_config;
  logic [31:0] hwdata, hrdata, rd;
  logic sleep_req, wake_req, supply_ok_n, ext_reset_n, watchdog_expire, brownout_low, watchdog_enable;
  logic converter_enable, comparator_enable, comparator_bandgap, comparator_use_mux;
  logic clk_en_timer_one, clk_en_timer_zero, clk_en_serial, clk_en_converter;
  logic io_access_timer_one, io_access_timer_zero, io_access_serial, io_access_converter;
  logic converter_on, converter_extended, comparator_on, comparator_mux_ok, reference_on;
  logic input_buffers_on, watchdog_run, brownout_on, pins_reset_n, core_reset_n, core_fetch_vector;
  logic [15:0] tcount, tsnap;
  int fails, comparisons, n;

  assign hready = hreadyout;
  power_gating_and_reset_control u_dut (.*);
  periph_model u_periph (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en_timer_zero), .count_q(tcount));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : bus

  task automatic wait_core;
    n = 0;
    while (core_reset_n !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
  endtask : wait_core

  task automatic report_and_stop;
    $display("Counts: %0d mismatches, %0d comparisons", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Run needs a few hundred cycles at most
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {hresetn, hsel, hwrite, sleep_req, wake_req, watchdog_expire, brownout_low, comparator_bandgap} = 8'h00;
    {supply_ok_n, ext_reset_n, watchdog_enable, comparator_enable, comparator_use_mux} = 5'h1F;
    {haddr, htrans, hsize, hwdata} = {8'h00, 2'h0, 3'h2, 32'h0};
    {brownout_level_config, startup_time_select, converter_enable} = {3'h7, 2'h0, 1'b0};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    wait_core();
    `CHK(n >= 16 && n <= 24, 1'b1)
    bus(1'b0, 8'h00, 32'h0, rd);
    `CHK(rd, 32'h0)
    bus(1'b0, 8'h08, 32'h0, rd);
    `CHK(rd, 32'h2)
    bus(1'b1, 8'h00, 32'hFFFFFFFF, rd);
    bus(1'b0, 8'h00, 32'h0, rd);
    `CHK(rd, 32'h0000000F)
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, 32'h1 << i, rd);
      repeat (3) @(posedge hclk);
      `CHK({clk_en_timer_one, clk_en_timer_zero, clk_en_serial, clk_en_converter}, 4'hF ^ (4'h1 << i))
      `CHK({io_access_timer_one, io_access_timer_zero, io_access_serial, io_access_converter}, 4'hF ^ (4'h1 << i))
      `CHK(comparator_mux_ok, i != 0)
    end
    bus(1'b1, 8'h00, 32'h4, rd);
    repeat (3) @(posedge hclk);
    tsnap = tcount;
    repeat (10) @(posedge hclk);
    `CHK(tcount, tsnap)
    bus(1'b1, 8'h00, 32'h0, rd);
    repeat (4) @(posedge hclk);
    `CHK(tcount > tsnap && tcount < tsnap + 16'h0008, 1'b1)
    converter_enable <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK({converter_on, converter_extended}, 2'h2)
    converter_enable <= 1'b0;
    @(posedge hclk);
    converter_enable <= 1'b1;
    @(posedge hclk);
    #1;
    `CHK(converter_extended, 1'b1)
    @(posedge hclk);
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h04, 32'(m), rd);
      sleep_req <= 1'b1;
      @(posedge hclk);
      sleep_req <= 1'b0;
      repeat (4) @(posedge hclk);
      `CHK({comparator_on, input_buffers_on, clk_en_timer_zero, watchdog_run, converter_on}, {m < 2, m < 2, m == 0, 2'h3})
      wake_req <= 1'b1;
      repeat (6) @(posedge hclk);
      wake_req <= 1'b0;
      @(posedge hclk);
    end
    bus(1'b0, 8'h04, 32'h0, rd);
    `CHK(rd, 32'h3)
    converter_enable <= 1'b0;
    bus(1'b1, 8'h00, 32'h3, rd);
    ext_reset_n <= 1'b0;
    repeat (10) @(posedge hclk);
    `CHK({pins_reset_n, core_reset_n}, 2'h0)
    ext_reset_n <= 1'b1;
    repeat (8) @(posedge hclk);
    watchdog_expire <= 1'b1;
    @(posedge hclk);
    watchdog_expire <= 1'b0;
    wait_core();
    `CHK(n >= 16 && n <= 24, 1'b1)
    bus(1'b0, 8'h00, 32'h0, rd);
    `CHK(rd, 32'h0)
    supply_ok_n <= 1'b0;
    #1;
    `CHK(pins_reset_n, 1'b0)
    repeat (4) @(posedge hclk);
    #1;
    `CHK(core_reset_n, 1'b0)
    @(posedge hclk);
    supply_ok_n <= 1'b1;
    wait_core();
    brownout_level_config <= 3'h1;
    brownout_low <= 1'b1;
    repeat (6) @(posedge hclk);
    `CHK({core_reset_n, reference_on, brownout_on}, 3'h3)
    brownout_low <= 1'b0;
    wait_core();
    report_and_stop();
  end
endmodule : power_gating_and_reset_control_tb_top

`default_nettype wire
